// ==== logic/servo_io_pkg.sv ====
package servo_io_pkg;

    // ========
    // Timing
    // ========
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned PROC_CYCLE_US = 250;
    localparam int unsigned PROC_CYCLE_CLKS = (CLK_HZ / 1_000_000) * PROC_CYCLE_US;
    localparam int TICK_W = 12;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(PROC_CYCLE_CLKS - 1);

    // ========
    // Register offsets
    // ========
    localparam logic [7:0] OFS_DEADBAND = 8'h00;
    localparam logic [7:0] OFS_SMOOTH = 8'h04;
    localparam logic [7:0] OFS_TRIGGER = 8'h08;
    localparam logic [7:0] OFS_ROLES = 8'h0c;
    localparam logic [7:0] OFS_IO_USE = 8'h10;
    localparam logic [7:0] OFS_AUX = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_FILT_DIFF = 8'h1c;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;

    // ========
    // Field layouts
    // ========
    typedef struct packed {
        logic [3:0] ch_two;
        logic [3:0] ch_one;
    } roles_t;

    typedef struct packed {
        logic gp_level;
        logic [1:0] fault_output_use;
        logic [1:0] travel_limit_use;
        logic [1:0] fault_clear_input_use;
        logic [1:0] enable_use;
    } io_use_t;

    typedef struct packed {
        logic [3:0] pulse_block_digit;
        logic [3:0] mode_choice_digit;
        logic [3:0] gear_choice_digit;
        logic [3:0] gain_choice_digit;
    } aux_fn_t;

    typedef struct packed {
        logic pulse_block_pin;
        logic gear_choice_pin;
        logic mode_choice_pin;
        logic gain_choice_pin;
        logic limit_pin_ccw;
        logic limit_pin_cw;
        logic fault_clear_pin;
        logic drive_enable_pin;
    } discrete_t;

    typedef struct packed {
        logic drive_enable;
        logic alternate_gain_set;
        logic second_gear_ratio;
        logic control_mode_b;
        logic pulse_block;
        logic stop_cw;
        logic stop_ccw;
    } func_out_t;

    // ========
    // Reset values and codes
    // ========
    localparam logic [7:0] DEADBAND_RST = 8'h00;
    localparam logic [13:0] SMOOTH_RST = 14'h01f4;
    localparam logic [13:0] SMOOTH_MIN = 14'h0001;
    localparam logic [13:0] SMOOTH_MAX = 14'h3e76;
    localparam int SMOOTH_SHIFT = 14;
    localparam logic [15:0] TRIGGER_RST = 16'h0000;
    localparam logic [7:0] ROLES_RST = 8'h33;
    localparam logic [8:0] IO_USE_RST = 9'h17e;
    localparam logic [15:0] AUX_RST = 16'h3333;
    localparam logic [3:0] DIGIT_1 = 4'h1;
    localparam logic [3:0] DIGIT_2 = 4'h2;
    localparam logic [1:0] USE_1 = 2'h1;
    localparam logic [1:0] USE_2 = 2'h2;
    localparam logic [1:0] USE_3 = 2'h3;
    localparam logic [7:0] CODE_LIMIT_CW = 8'h01;
    localparam logic [7:0] CODE_LIMIT_CCW = 8'h02;

    // Interrupt bit positions
    localparam int IRQ_W = 5;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_CLEARED = 1;
    localparam int IRQ_LIMIT_CW = 2;
    localparam int IRQ_LIMIT_CCW = 3;
    localparam int IRQ_SENSOR = 4;

endpackage

// ==== logic/servo_io_function_mapper.sv ====
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module servo_io_function_mapper (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Discrete pins, 1 = closed
    input wire servo_io_pkg::discrete_t discrete_pins,
    // Digitised analog samples, signed mV, core_clk domain
    input wire logic signed [15:0] analog_channel_one,
    input wire logic signed [15:0] analog_channel_two,
    input wire logic signed [15:0] diff_sample,
    // Drive fault source
    input wire logic fault_set,
    input wire logic [7:0] fault_code_in,
    // Function outputs
    output servo_io_pkg::func_out_t func_out,
    output logic fault_output_pin,
    output logic signed [15:0] velocity_ref,
    output logic signed [15:0] torque_ref,
    output logic sensor_state,
    output logic irq
);
    import servo_io_pkg::*;

    // ========
    // Reset release
    // ========
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ========
    // Processor cycle tick
    // ========
    // Every function update waits for it
    logic [TICK_W-1:0] tick_cnt_reg;
    logic tick_reg;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (tick_cnt_reg == TICK_LAST);
            tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // ========
    // Function digit decoding
    // ========
    // Digit 1 follows the level, 2 its inverse, anything else is inactive
    function automatic logic pick(input logic [3:0] digit, input logic level);
        pick = (digit == DIGIT_1) ? level : ((digit == DIGIT_2) ? ~level : 1'b0);
    endfunction

    // ========
    // Registers
    // ========
    logic [7:0] deadband_reg;
    logic [13:0] smooth_reg;
    logic signed [15:0] trigger_reg;
    roles_t roles_reg;
    io_use_t io_use_reg;
    aux_fn_t aux_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_stat_next;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [IRQ_W-1:0] irq_event;
    logic fault_active_reg;
    logic [7:0] fault_code_reg;
    logic signed [15:0] filt_reg [3];
    discrete_t pin_state_reg;

    // ========
    // AHB-Lite slave
    // ========
    // Zero wait states, hsize ignored
    logic accept;
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    logic stat_read;
    logic [13:0] smooth_wr;
    logic [31:0] rd_value;

    assign accept = hsel & htrans[1] & hready;
    assign stat_read = accept & ~hwrite & (haddr[7:0] == OFS_IRQ_STAT);
    assign smooth_wr = (hwdata[13:0] < SMOOTH_MIN) ? SMOOTH_MIN :
                       ((hwdata[13:0] > SMOOTH_MAX) ? SMOOTH_MAX : hwdata[13:0]);

    always_comb begin
        rd_value = 32'h0000_0000;
        if (haddr[7:0] == OFS_DEADBAND) begin
            rd_value[7:0] = deadband_reg;
        end else if (haddr[7:0] == OFS_SMOOTH) begin
            rd_value[13:0] = smooth_reg;
        end else if (haddr[7:0] == OFS_TRIGGER) begin
            rd_value[15:0] = trigger_reg;
        end else if (haddr[7:0] == OFS_ROLES) begin
            rd_value[7:0] = roles_reg;
        end else if (haddr[7:0] == OFS_IO_USE) begin
            rd_value[8:0] = io_use_reg;
        end else if (haddr[7:0] == OFS_AUX) begin
            rd_value[15:0] = aux_reg;
        end else if (haddr[7:0] == OFS_STATUS) begin
            rd_value = {8'h00, fault_code_reg, 6'h00, fault_active_reg, sensor_state,
                        pin_state_reg};
        end else if (haddr[7:0] == OFS_FILT_DIFF) begin
            rd_value[15:0] = filt_reg[2];
        end else if (haddr[7:0] == OFS_IRQ_STAT) begin
            rd_value[IRQ_W-1:0] = irq_stat_reg;
        end else if (haddr[7:0] == OFS_IRQ_MASK) begin
            rd_value[IRQ_W-1:0] = irq_mask_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_reg <= accept & hwrite;
            if (accept) begin
                wr_addr_reg <= haddr[7:0];
            end
            if (accept & ~hwrite) begin
                hrdata <= rd_value;
            end
        end
    end

    // Settings other than the interrupt mask are only sampled on the tick, so a write acts at the next tick
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            deadband_reg <= DEADBAND_RST;
            smooth_reg <= SMOOTH_RST;
            trigger_reg <= TRIGGER_RST;
            roles_reg <= ROLES_RST;
            io_use_reg <= IO_USE_RST;
            aux_reg <= AUX_RST;
            irq_mask_reg <= '0;
        end else if (wr_pend_reg) begin
            if (wr_addr_reg == OFS_DEADBAND) begin
                deadband_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_SMOOTH) begin
                smooth_reg <= smooth_wr;
            end else if (wr_addr_reg == OFS_TRIGGER) begin
                trigger_reg <= hwdata[15:0];
            end else if (wr_addr_reg == OFS_ROLES) begin
                roles_reg <= hwdata[7:0];
            end else if (wr_addr_reg == OFS_IO_USE) begin
                io_use_reg <= hwdata[8:0];
            end else if (wr_addr_reg == OFS_AUX) begin
                aux_reg <= hwdata[15:0];
            end else if (wr_addr_reg == OFS_IRQ_MASK) begin
                irq_mask_reg <= hwdata[IRQ_W-1:0];
            end
        end
    end

    // ========
    // Discrete pin synchroniser
    // ========
    // Agreement rejects one-clock glitches
    discrete_t sync1_reg;
    discrete_t sync2_reg;
    discrete_t sync3_reg;
    logic [7:0] agree;

    assign agree = ~(sync2_reg ^ sync3_reg);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            sync3_reg <= '0;
            pin_state_reg <= '0;
        end else begin
            sync1_reg <= discrete_pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            pin_state_reg <= (sync2_reg & agree) | (pin_state_reg & ~agree);
        end
    end

    // ========
    // Analog deadband and filters
    // ========
    logic [16:0] diff_mag;
    logic signed [15:0] diff_zoned;
    logic signed [15:0] filt_in [3];

    assign diff_mag = diff_sample[15] ? 17'(-$signed({diff_sample[15], diff_sample}))
                                      : {1'b0, diff_sample};
    assign diff_zoned = (diff_mag <= {9'h000, deadband_reg}) ? 16'sh0000 : diff_sample;
    assign filt_in[0] = analog_channel_one;
    assign filt_in[1] = analog_channel_two;
    assign filt_in[2] = diff_zoned;

    // Step never exceeds the error, so the sum never leaves 16 bits
    for (genvar g = 0; g < 3; g++) begin : g_filt
        logic signed [16:0] err;
        logic signed [31:0] prod;
        logic signed [17:0] sum;
        assign err = 17'(filt_in[g]) - 17'(filt_reg[g]);
        assign prod = err * $signed({1'b0, smooth_reg});
        assign sum = 18'(filt_reg[g]) + 18'(prod >>> SMOOTH_SHIFT);
        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                filt_reg[g] <= 16'sh0000;
            end else if (tick_reg) begin
                filt_reg[g] <= sum[15:0];
            end
        end
    end

    // ========
    // Function mapping, once per processor cycle
    // ========
    // Outputs hold steady between ticks
    logic limit_cw_act;
    logic limit_ccw_act;
    logic clear_act;
    logic clear_prev_reg;
    logic clear_edge;
    logic new_cw;
    logic new_ccw;
    logic sensor_next;

    // Digit value 3 (or 0) leaves every pin free
    assign limit_cw_act = pick({2'b00, io_use_reg.travel_limit_use},
                               pin_state_reg.limit_pin_cw);
    assign limit_ccw_act = pick({2'b00, io_use_reg.travel_limit_use},
                                pin_state_reg.limit_pin_ccw);
    assign clear_act = pick({2'b00, io_use_reg.fault_clear_input_use},
                            pin_state_reg.fault_clear_pin);
    assign clear_edge = tick_reg & clear_act & ~clear_prev_reg;
    assign new_cw = tick_reg & limit_cw_act & ~func_out.stop_cw;
    assign new_ccw = tick_reg & limit_ccw_act & ~func_out.stop_ccw;
    assign sensor_next = (filt_reg[2] >= trigger_reg);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            func_out <= '0;
            clear_prev_reg <= 1'b0;
            sensor_state <= 1'b0;
            velocity_ref <= 16'sh0000;
            torque_ref <= 16'sh0000;
        end else if (tick_reg) begin
            clear_prev_reg <= clear_act;
            sensor_state <= sensor_next;
            func_out.drive_enable <= (io_use_reg.enable_use == USE_3) ? 1'b1 :
                pick({2'b00, io_use_reg.enable_use}, ~pin_state_reg.drive_enable_pin);
            func_out.alternate_gain_set <= pick(aux_reg.gain_choice_digit,
                                                ~pin_state_reg.gain_choice_pin);
            func_out.second_gear_ratio <= pick(aux_reg.gear_choice_digit,
                                               pin_state_reg.gear_choice_pin);
            func_out.control_mode_b <= pick(aux_reg.mode_choice_digit,
                                            ~pin_state_reg.mode_choice_pin);
            func_out.pulse_block <= pick(aux_reg.pulse_block_digit,
                                         pin_state_reg.pulse_block_pin);
            func_out.stop_cw <= limit_cw_act;
            func_out.stop_ccw <= limit_ccw_act;
            velocity_ref <= (roles_reg.ch_one == DIGIT_1) ? filt_reg[0] : 16'sh0000;
            torque_ref <= (roles_reg.ch_two == DIGIT_2) ? filt_reg[1] : 16'sh0000;
        end
    end

    // ========
    // Drive fault and alarm output
    // ========
    // A new fault in the same cycle as a clear survives
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_active_reg <= 1'b0;
            fault_code_reg <= 8'h00;
        end else if (fault_set | new_cw | new_ccw) begin
            fault_active_reg <= 1'b1;
            fault_code_reg <= fault_set ? fault_code_in :
                              (new_cw ? CODE_LIMIT_CW : CODE_LIMIT_CCW);
        end else if (clear_edge) begin
            fault_active_reg <= 1'b0;
            fault_code_reg <= 8'h00;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_output_pin <= 1'b1;
        end else if (tick_reg) begin
            if (io_use_reg.fault_output_use == USE_1) begin
                fault_output_pin <= ~fault_active_reg;
            end else if (io_use_reg.fault_output_use == USE_2) begin
                fault_output_pin <= fault_active_reg;
            end else begin
                fault_output_pin <= io_use_reg.gp_level;
            end
        end
    end

    // ========
    // Interrupts
    // ========
    // A same-cycle event beats read clear
    always_comb begin
        irq_event = '0;
        irq_event[IRQ_FAULT] = fault_set | new_cw | new_ccw;
        irq_event[IRQ_CLEARED] = clear_edge;
        irq_event[IRQ_LIMIT_CW] = new_cw;
        irq_event[IRQ_LIMIT_CCW] = new_ccw;
        irq_event[IRQ_SENSOR] = tick_reg & (sensor_next != sensor_state);
        irq_stat_next = (stat_read ? '0 : irq_stat_reg) | irq_event;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= '0;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= irq_stat_next;
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

endmodule // servo_io_function_mapper

// ==== tb/host_io_model.sv ====
`timescale 1ns/1ns
// ========
// Host controller model
// ========
module host_io_model (
    // Commands from the bench
    input wire servo_io_pkg::discrete_t pins_cmd,
    input wire logic signed [15:0] one_cmd,
    input wire logic signed [15:0] two_cmd,
    input wire logic signed [15:0] diff_cmd,
    input wire logic fault_cmd,
    input wire logic [7:0] code_cmd,
    // Toward the drive
    output servo_io_pkg::discrete_t discrete_pins,
    output logic signed [15:0] analog_channel_one,
    output logic signed [15:0] analog_channel_two,
    output logic signed [15:0] diff_sample,
    output logic fault_set,
    output logic [7:0] fault_code_in
);
    import servo_io_pkg::*;
    // Levels pass straight through from the bench commands
    assign discrete_pins = pins_cmd;
    assign analog_channel_one = one_cmd;
    assign analog_channel_two = two_cmd;
    assign diff_sample = diff_cmd;
    assign fault_set = fault_cmd;
    // Code bus is only meaningful with the pulse, so show garbage otherwise
    assign fault_code_in = fault_cmd ? code_cmd : ~code_cmd;
endmodule // host_io_model

// ==== tb/io_mapper_assertions.sv ====
`timescale 1ns/1ns
module io_mapper_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Function side
    input wire servo_io_pkg::func_out_t func_out,
    input wire logic fault_output_pin,
    input wire logic signed [15:0] velocity_ref,
    input wire logic signed [15:0] torque_ref,
    input wire logic sensor_state,
    input wire logic irq
);
    import servo_io_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    // ========
    // Helpers
    // ========
    logic take, rd, irq_acc, chg, seen;
    logic [2:0] acc_q;
    logic [40:0] outs_now, outs_q;
    logic [31:0] gap;
    assign take = hsel && htrans[1] && hready;
    assign rd = take && !hwrite;
    assign irq_acc = take && (haddr[7:0] == OFS_IRQ_STAT || haddr[7:0] == OFS_IRQ_MASK);
    assign outs_now = {func_out, fault_output_pin, velocity_ref, torque_ref, sensor_state};
    assign chg = outs_now != outs_q;
    // First change after reset only starts the count; tick phase is unknown
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            acc_q <= 3'h0;
            outs_q <= 41'h200000000;
            seen <= 1'b0;
            gap <= 32'h0;
        end else begin
            acc_q <= {acc_q[1:0], irq_acc};
            outs_q <= outs_now;
            seen <= seen | chg;
            gap <= chg ? 32'h0 : gap + 32'h1;
        end
    end
    // ========
    // Properties
    // ========
    a_tick_spacing: assert property (
        chg && seen |-> gap % PROC_CYCLE_CLKS == PROC_CYCLE_CLKS - 1)
        else $error("Outputs moved off the processor cycle");
    a_irq_fall_cause: assert property ($fell(irq) |-> acc_q[1] || acc_q[2])
        else $error("Interrupt dropped without status read or mask write");
    a_rdata_holds: assert property (!rd |=> $stable(hrdata))
        else $error("Read data changed without a read");
    a_unmapped_zero: assert property (rd && haddr[7:0] > 8'h27 |=> hrdata == 32'h0)
        else $error("Unmapped read not zero");
    a_deadband_width: assert property (
        rd && haddr[7:0] == OFS_DEADBAND |=> hrdata[31:8] == 24'h0)
        else $error("Deadband readback too wide");
    a_mask_width: assert property (
        rd && haddr[7:0] == OFS_IRQ_MASK |=> hrdata[31:5] == 27'h0)
        else $error("Mask readback too wide");
    a_ready_high: assert property (take |-> hreadyout [*2])
        else $error("Wait state inserted");
    a_resp_okay: assert property (take |-> ##1 (hresp == 1'b0) [*2])
        else $error("Error response given");
    c_irq_rise: cover property ($rose(irq));
    c_fault_pin: cover property ($fell(fault_output_pin));
    c_stop_cw: cover property ($rose(func_out.stop_cw));
endmodule // io_mapper_assertions

bind servo_io_function_mapper io_mapper_assertions u_io_chk (
    .core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .func_out(func_out), .fault_output_pin(fault_output_pin), .velocity_ref(velocity_ref),
    .torque_ref(torque_ref), .sensor_state(sensor_state), .irq(irq));

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import servo_io_pkg::*;
    localparam int DB = 100;
    logic core_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, fault_cmd = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp, fault_set, fault_output_pin, sensor_state, irq;
    logic signed [15:0] one_cmd = 16'h0, two_cmd = 16'h0, diff_cmd = 16'h0;
    logic signed [15:0] analog_channel_one, analog_channel_two, diff_sample;
    logic signed [15:0] velocity_ref, torque_ref;
    logic [7:0] code_cmd = 8'h0, fault_code_in, roles;
    discrete_t pins_cmd = 8'h0, discrete_pins;
    func_out_t func_out;
    logic [8:0] use_v = IO_USE_RST;
    logic [15:0] aux = AUX_RST;
    int miscompares = 0, n_tests = 0, cycles = 0, yd = 0, y1 = 0, y2 = 0;
    int trig, x1, x2, xd, k;
    int dtab [4] = '{DB, -DB, DB + 1, -DB - 1};
    logic [7:0] r_ofs [8] = '{OFS_DEADBAND, OFS_SMOOTH, OFS_TRIGGER, OFS_ROLES, OFS_IO_USE,
        OFS_AUX, OFS_IRQ_MASK, 8'h30};
    logic [31:0] r_val [8] = '{32'h0, 32'h1f4, 32'h0, 32'h33, 32'h17e, 32'h3333, 32'h0, 32'h0};
    assign hready = hreadyout;
    host_io_model u_host (.pins_cmd(pins_cmd), .one_cmd(one_cmd), .two_cmd(two_cmd),
        .diff_cmd(diff_cmd), .fault_cmd(fault_cmd), .code_cmd(code_cmd),
        .discrete_pins(discrete_pins), .analog_channel_one(analog_channel_one),
        .analog_channel_two(analog_channel_two), .diff_sample(diff_sample),
        .fault_set(fault_set), .fault_code_in(fault_code_in));
    servo_io_function_mapper DUT (.core_clk(core_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .discrete_pins(discrete_pins),
        .analog_channel_one(analog_channel_one), .analog_channel_two(analog_channel_two),
        .diff_sample(diff_sample), .fault_set(fault_set), .fault_code_in(fault_code_in),
        .func_out(func_out), .fault_output_pin(fault_output_pin), .velocity_ref(velocity_ref),
        .torque_ref(torque_ref), .sensor_state(sensor_state), .irq(irq));
    always #50 core_clk = ~core_clk;
    // ========
    // Model and tasks
    // ========
    function automatic logic sel(input logic [3:0] d, input logic v);
        return (d == DIGIT_1) ? v : (d == DIGIT_2) ? !v : 1'b0;
    endfunction
    function automatic int filt(input int y, input int x);
        repeat (40) y = y + (((x - y) * int'(SMOOTH_MAX)) >>> SMOOTH_SHIFT);
        return y;
    endfunction
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Mode output is masked while its pin is free
    task automatic check_fn(input logic f);
        logic [7:0] p, e, m;
        p = pins_cmd;
        m = {3'h7, aux[11:8] != 4'h3, 4'hf};
        e = {(use_v[1:0] == USE_3) | sel({2'h0, use_v[1:0]}, !p[0]), sel(aux[3:0], !p[4]),
            sel(aux[7:4], p[6]), sel(aux[11:8], !p[5]), sel(aux[15:12], p[7]),
            sel({2'h0, use_v[5:4]}, p[2]), sel({2'h0, use_v[5:4]}, p[3]),
            (use_v[7:6] == USE_1) ? !f : (use_v[7:6] == USE_2) ? f : use_v[8]};
        n_tests++;
        if ((({func_out, fault_output_pin} ^ e) & m) !== 8'h0) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, {func_out, fault_output_pin}, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    task automatic settle(input logic f, input logic [7:0] c);
        repeat (2 * PROC_CYCLE_CLKS + 10) @(posedge core_clk);
        check_fn(f);
        bus(1'b0, OFS_STATUS, 32'h0);
        check_reg(rd & 32'h00ff02ff, {8'h0, c, 6'h0, f, 1'b0, pins_cmd});
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 97000) begin
            miscompares++;
            complete_run();
        end
    end
    // ========
    // Main sequence
    // ========
    initial begin
        void'($urandom(32'hb96ab999));
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge core_clk);
        bus(1'b1, 8'h30, 32'hffffffff);
        foreach (r_ofs[i]) begin
            bus(1'b0, r_ofs[i], 32'h0);
            check_reg(rd, r_val[i]);
        end
        bus(1'b1, OFS_SMOOTH, 32'h0);
        bus(1'b0, OFS_SMOOTH, 32'h0);
        check_reg(rd, 32'h1);
        bus(1'b1, OFS_SMOOTH, 32'h3fff);
        bus(1'b0, OFS_SMOOTH, 32'h0);
        check_reg(rd, 32'd15990);
        bus(1'b1, OFS_DEADBAND, 32'(DB));
        bus(1'b0, OFS_DEADBAND, 32'h0);
        check_reg(rd, 32'(DB));
        for (int i = 0; i < 5; i++) begin
            roles = {4'($urandom_range(1, 3)), 4'($urandom_range(1, 3))};
            aux = {4'($urandom_range(1, 3)), 4'($urandom_range(1, 3)),
                4'($urandom_range(1, 3)), 4'($urandom_range(1, 3))};
            use_v = {1'($urandom_range(0, 1)), 2'($urandom_range(1, 3)), 4'hf,
                2'($urandom_range(1, 3))};
            trig = int'($urandom_range(0, 400)) - 200;
            x1 = int'($urandom_range(0, 4000)) - 2000;
            x2 = int'($urandom_range(0, 4000)) - 2000;
            k = int'($urandom_range(0, 5));
            xd = (k < 4) ? dtab[k] : int'($urandom_range(0, 4000)) - 2000;
            bus(1'b1, OFS_ROLES, {24'h0, roles});
            bus(1'b1, OFS_AUX, {16'h0, aux});
            bus(1'b1, OFS_IO_USE, {23'h0, use_v});
            bus(1'b1, OFS_TRIGGER, {16'h0, 16'(trig)});
            pins_cmd <= discrete_t'($urandom);
            one_cmd <= 16'(x1);
            two_cmd <= 16'(x2);
            diff_cmd <= 16'(xd);
            repeat (5 * PROC_CYCLE_CLKS + 10) @(posedge core_clk);
            yd = filt(yd, (xd <= DB && xd >= -DB) ? 0 : xd);
            y1 = filt(y1, x1);
            y2 = filt(y2, x2);
            check_fn(1'b0);
            bus(1'b0, OFS_FILT_DIFF, 32'h0);
            check_reg(rd, {16'h0, 16'(yd)});
            check_reg({velocity_ref, torque_ref}, {(roles[3:0] == DIGIT_1) ? 16'(y1) : 16'h0,
                (roles[7:4] == DIGIT_2) ? 16'(y2) : 16'h0});
            check_reg({31'h0, sensor_state}, {31'h0, yd >= trig});
        end
        // Pins settle before limits are armed, else an old level reads as a hit
        pins_cmd <= 8'h0;
        repeat (8) @(posedge core_clk);
        use_v = 9'h156;
        bus(1'b1, OFS_IO_USE, 32'h156);
        settle(1'b0, 8'h0);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        fault_cmd <= 1'b1;
        code_cmd <= 8'h5a;
        @(posedge core_clk);
        fault_cmd <= 1'b0;
        repeat (4) @(posedge core_clk);
        check_reg({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h1f);
        repeat (4) @(posedge core_clk);
        check_reg({31'h0, irq}, 32'h1);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        check_reg(rd, 32'h1);
        repeat (4) @(posedge core_clk);
        check_reg({31'h0, irq}, 32'h0);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        settle(1'b1, 8'h5a);
        pins_cmd <= 8'h02;
        settle(1'b0, 8'h0);
        pins_cmd <= 8'h04;
        settle(1'b1, CODE_LIMIT_CW);
        use_v = 9'h196;
        bus(1'b1, OFS_IO_USE, 32'h196);
        settle(1'b1, CODE_LIMIT_CW);
        use_v = 9'h1b6;
        bus(1'b1, OFS_IO_USE, 32'h1b6);
        pins_cmd <= 8'h0a;
        settle(1'b0, 8'h0);
        complete_run();
    end
endmodule // testbench
